// >>> inc/cpu8_decode_pkg.sv
package cpu8_decode_pkg;
  // Opcode match fields, taken from the top of the word
  localparam logic [5:0]  HI6_ADDC    = 6'h08;
  localparam logic [5:0]  HI6_DECSNZ  = 6'h13;
  localparam logic [5:0]  HI6_SUB_AF  = 6'h16;
  localparam logic [5:0]  HI6_SUB_FA  = 6'h15;
  localparam logic [5:0]  HI6_RLC     = 6'h0d;
  localparam logic [6:0]  HI7_CPLT    = 7'h30;
  localparam logic [6:0]  HI7_CPEQ    = 7'h31;
  localparam logic [6:0]  HI7_CPGT    = 7'h32;
  localparam logic [6:0]  HI7_CALL    = 7'h76;
  localparam logic [3:0]  HI4_BTSC    = 4'hb;
  localparam logic [3:0]  HI4_BTSS    = 4'ha;
  localparam logic [3:0]  HI4_SECOND  = 4'hf;
  localparam logic [4:0]  HI5_BRANCH  = 5'h1c;
  localparam logic [7:0]  HI8_GOTO    = 8'hef;
  localparam logic [7:0]  HI8_RETLIT  = 8'h0c;
  localparam logic [7:0]  HI8_ANDL    = 8'h0b;
  localparam logic [14:0] HI15_RETIRQ = 15'h0008;
  localparam logic [15:0] WORD_SLEEP  = 16'h0003;
  localparam logic [15:0] WORD_PUSH   = 16'h0005;
  // Field positions and address map
  localparam int unsigned BIT_DEST        = 9;
  localparam int unsigned BIT_ACCESS      = 8;
  localparam logic [7:0]  ACCESS_LIMIT    = 8'h5f;
  localparam logic [3:0]  BANK_LOW        = 4'h0;
  localparam logic [3:0]  BANK_SFR        = 4'hf;
  localparam logic [11:0] PORT_ADDR_DEF   = 12'hf80;
  localparam logic [11:0] TIMER0_ADDR_DEF = 12'hfd0;
  // Status flag positions and reset values
  localparam int unsigned FLAG_C   = 0;
  localparam int unsigned FLAG_DIG = 1;
  localparam int unsigned FLAG_Z   = 2;
  localparam int unsigned FLAG_OVF = 3;
  localparam int unsigned FLAG_N   = 4;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [4:0]  FLAGS_RST = 5'h00;

  typedef enum logic [1:0] {PH_Q1 = 2'h0, PH_Q2 = 2'h1, PH_Q3 = 2'h2, PH_Q4 = 2'h3} phase_e;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADDC = 5'h01, OP_SUB_AF = 5'h02, OP_SUB_FA = 5'h03, OP_RLC = 5'h04,
    OP_DECSNZ = 5'h05, OP_CPEQ = 5'h06, OP_CPGT = 5'h07, OP_CPLT = 5'h08, OP_BTSC = 5'h09,
    OP_BTSS = 5'h0a, OP_BRANCH = 5'h0b, OP_CALL = 5'h0c, OP_GOTO = 5'h0d, OP_SECOND = 5'h0e,
    OP_SLEEP = 5'h0f, OP_PUSH = 5'h10, OP_RETIRQ = 5'h11, OP_RETLIT = 5'h12, OP_ANDL = 5'h13
  } op_e;
  typedef enum logic [2:0] {
    ALU_PASS = 3'h0, ALU_ADDC = 3'h1, ALU_SUB_AF = 3'h2, ALU_SUB_FA = 3'h3,
    ALU_AND = 3'h4, ALU_RLC = 3'h5, ALU_DEC = 3'h6
  } alu_e;
endpackage

// >>> inc/alu_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operands and results between decoder and arithmetic unit
interface alu_if;
  import cpu8_decode_pkg::*;
  alu_e       op;      // Operation select
  logic [7:0] a;       // Accumulator operand
  logic [7:0] b;       // File or literal operand
  logic       cin;     // Carry in
  logic [7:0] result;  // Arithmetic result
  logic       cout;    // Carry out
  logic       digOut;  // Nibble carry
  logic       ovfOut;  // Signed overflow
  logic       zOut;    // Result is zero
  logic       nOut;    // Result sign
  modport decoder (output op, a, b, cin, input result, cout, digOut, ovfOut, zOut, nOut);
  modport alu (input op, a, b, cin, output result, cout, digOut, ovfOut, zOut, nOut);
endinterface
`default_nettype wire

// >>> verilog/alu_unit.sv
`timescale 1ns/1ps
`default_nettype none

module alu_unit
  import cpu8_decode_pkg::*;
(
  alu_if.alu bus
);
  logic [7:0] x;    // Adder left input
  logic [7:0] y;    // Adder right input
  logic [8:0] sum;  // Full sum with carry
  logic [4:0] low;  // Low nibble sum for digit carry
  logic [7:0] r;    // Selected result

  // One adder serves both subtractions: borrow is the inverted carry
  always_comb begin
    x = bus.a;
    y = bus.b;
    if (bus.op == ALU_SUB_AF) begin  // File minus accumulator
      x = bus.b;
      y = ~bus.a;
    end else if (bus.op == ALU_SUB_FA) begin  // Accumulator minus file
      y = ~bus.b;
    end
    sum = {1'b0, x} + {1'b0, y} + {8'h00, bus.cin};
    low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, bus.cin};
  end

  // Result select and flag outputs
  always_comb begin
    r = sum[7:0];
    bus.cout = sum[8];
    case (bus.op)
      ALU_AND:  r = bus.a & bus.b;
      ALU_RLC: begin  // Carry enters at bit 0, bit 7 leaves
        r = {bus.b[6:0], bus.cin};
        bus.cout = bus.b[7];
      end
      ALU_DEC:  r = bus.b - 8'h01;
      ALU_PASS: r = bus.b;
      default:  r = sum[7:0];
    endcase
    bus.result = r;
    bus.digOut = low[4];
    bus.ovfOut = (x[7] == y[7]) && (sum[7] != x[7]);
    bus.zOut = (r == 8'h00);
    bus.nOut = r[7];
  end
endmodule
`default_nettype wire

// >>> verilog/cpu8_instruction_decode.sv
`timescale 1ns/1ps
`default_nettype none

module cpu8_instruction_decode
  import cpu8_decode_pkg::*;
#(
  parameter logic [11:0] PORT_ADDR   = PORT_ADDR_DEF,   // Port whose pins feed reads
  parameter logic [11:0] TIMER0_ADDR = TIMER0_ADDR_DEF  // Timer zero counter
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [15:0] instrWord,
  input  wire logic [7:0]  fileData,
  input  wire logic [7:0]  portPins,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [11:0] indexBase,
  input  wire logic        extendedEn,
  input  wire logic        prescalerAssigned,
  output logic [1:0]       quarterPhase,
  output logic             fetchStrobe,
  output logic             nopCycle,
  output logic [11:0]      dataAddr,
  output logic             fileWriteEn,
  output logic [7:0]       fileWriteData,
  output logic [7:0]       accumulator,
  output logic [4:0]       statusFlags,
  output logic             watchdogExpired,
  output logic             powerDown,
  output logic             gieHigh,
  output logic             gieLow,
  output logic             jumpEn,
  output logic             jumpRelative,
  output logic [19:0]      jumpTarget,
  output logic             stackPush,
  output logic             stackPop,
  output logic             sleepReq,
  output logic             prescalerClear
);
  // Port and timer must not share one address
  if (PORT_ADDR == TIMER0_ADDR) begin : g_bad_map
    $error("Port and timer zero addresses collide");
  end

  // Whole decoder state in one record
  typedef struct packed {
    phase_e      phase;     // Quarter of the instruction cycle
    op_e         op;        // Decoded operation
    logic [15:0] instr;     // Word under execution
    logic        pend;      // Second word of call or jump awaited
    logic        pendCall;  // Pending pair is a call
    logic [7:0]  pendLow;   // Low target bits from first word
    logic        flush;     // Next word runs as no-op
    logic        skip;      // Skip or branch condition met
    logic [7:0]  operand;   // Source operand read in Q2
    logic [7:0]  result;    // Result formed in Q3
    logic [4:0]  newFlags;  // Flags formed in Q3
    logic [7:0]  pinMeta;   // Pin synchroniser, first stage
    logic [7:0]  pinSync;   // Pin synchroniser, second stage
    logic [7:0]  acc;       // Working accumulator
    logic [4:0]  flags;     // Arithmetic status
    logic        wdtExp;    // Watchdog expired flag
    logic        pwrDown;   // Powerdown flag
    logic        gieH;      // High priority enable
    logic        gieL;      // Low priority enable
    logic [11:0] addr;      // Data memory address
    logic        fetch;     // Next word request
    logic        fileWe;    // File write strobe
    logic [7:0]  fileWd;    // File write data
    logic        jump;      // Program counter load
    logic        jumpRel;   // Load is relative
    logic [19:0] jumpTgt;   // Target or offset
    logic        push;      // Return stack push
    logic        pop;       // Return stack pop and return
    logic        sleep;     // Standby request
    logic        prescClr;  // Timer prescaler clear
    logic        nop;       // Current cycle is a no-op
  } state_s;

  state_s s_r;    // Registered state
  state_s s_nxt;  // Next state

  alu_if aluBus ();  // Link to arithmetic unit

  alu_unit u_alu (
    .bus (aluBus.alu)
  );

  // Operation class from an instruction word
  function automatic op_e decodeOp(input logic [15:0] w);
    op_e o;
    o = OP_NOP;  // Unknown and lone second words fall to no-op
    if (w[15:10] == HI6_ADDC) o = OP_ADDC;
    else if (w[15:10] == HI6_SUB_AF) o = OP_SUB_AF;
    else if (w[15:10] == HI6_SUB_FA) o = OP_SUB_FA;
    else if (w[15:10] == HI6_RLC) o = OP_RLC;
    else if (w[15:10] == HI6_DECSNZ) o = OP_DECSNZ;
    else if (w[15:9] == HI7_CPEQ) o = OP_CPEQ;
    else if (w[15:9] == HI7_CPGT) o = OP_CPGT;
    else if (w[15:9] == HI7_CPLT) o = OP_CPLT;
    else if (w[15:12] == HI4_BTSC) o = OP_BTSC;
    else if (w[15:12] == HI4_BTSS) o = OP_BTSS;
    else if (w[15:11] == HI5_BRANCH) o = OP_BRANCH;
    else if (w[15:9] == HI7_CALL) o = OP_CALL;
    else if (w[15:8] == HI8_GOTO) o = OP_GOTO;
    else if (w == WORD_SLEEP) o = OP_SLEEP;
    else if (w == WORD_PUSH) o = OP_PUSH;
    else if (w[15:1] == HI15_RETIRQ) o = OP_RETIRQ;
    else if (w[15:8] == HI8_RETLIT) o = OP_RETLIT;
    else if (w[15:8] == HI8_ANDL) o = OP_ANDL;
    return o;
  endfunction

  // Byte operations that honour the destination bit
  function automatic logic byteOp(input op_e o);
    return (o == OP_ADDC) || (o == OP_SUB_AF) || (o == OP_SUB_FA) ||
           (o == OP_RLC) || (o == OP_DECSNZ);
  endfunction

  // Data memory address from the file field
  function automatic logic [11:0] fileAddr(input logic [15:0] w, input logic [3:0] bank,
                                           input logic [11:0] base, input logic ext);
    logic [11:0] a;
    a = {bank, w[7:0]};
    if (!w[BIT_ACCESS]) begin
      if (ext && (w[7:0] <= ACCESS_LIMIT)) a = base + {4'h0, w[7:0]};
      else if (w[7:0] <= ACCESS_LIMIT) a = {BANK_LOW, w[7:0]};
      else a = {BANK_SFR, w[7:0]};
    end
    return a;
  endfunction

  // Branch condition from the second nibble
  function automatic logic branchTrue(input logic [2:0] c, input logic [4:0] f);
    logic t;
    case (c[2:1])
      2'h0:    t = f[FLAG_Z];
      2'h1:    t = f[FLAG_C];
      2'h2:    t = f[FLAG_OVF];
      default: t = f[FLAG_N];
    endcase
    return c[0] ? !t : t;  // Odd codes test the negated flag
  endfunction

  // Arithmetic unit inputs follow the decoded operation
  always_comb begin
    aluBus.a = s_r.acc;
    aluBus.b = s_r.operand;
    aluBus.cin = s_r.flags[FLAG_C];
    case (s_r.op)
      OP_ADDC:   aluBus.op = ALU_ADDC;
      OP_SUB_AF: aluBus.op = ALU_SUB_AF;
      OP_SUB_FA: aluBus.op = ALU_SUB_FA;
      OP_RLC:    aluBus.op = ALU_RLC;
      OP_DECSNZ: aluBus.op = ALU_DEC;
      OP_ANDL:   aluBus.op = ALU_AND;
      default:   aluBus.op = ALU_PASS;
    endcase
  end

  // Phase sequencer and execution
  always_comb begin
    s_nxt = s_r;
    s_nxt.pinMeta = portPins;
    s_nxt.pinSync = s_r.pinMeta;
    // Strobes last one enabled cycle
    s_nxt.fetch = 1'b0;
    s_nxt.fileWe = 1'b0;
    s_nxt.jump = 1'b0;
    s_nxt.push = 1'b0;
    s_nxt.pop = 1'b0;
    s_nxt.sleep = 1'b0;
    s_nxt.prescClr = 1'b0;
    case (s_r.phase)
      PH_Q1: begin
        s_nxt.phase = PH_Q2;
        s_nxt.instr = instrWord;
        s_nxt.nop = s_r.flush;
        s_nxt.flush = 1'b0;
        s_nxt.pend = 1'b0;
        s_nxt.skip = 1'b0;
        s_nxt.addr = fileAddr(instrWord, bankSelect, indexBase, extendedEn);
        if (s_r.flush) begin
          s_nxt.op = OP_NOP;
        end else if (s_r.pend && (instrWord[15:12] == HI4_SECOND)) begin
          s_nxt.op = OP_SECOND;
        end else begin
          s_nxt.op = decodeOp(instrWord);
        end
      end
      PH_Q2: begin
        s_nxt.phase = PH_Q3;
        if ((s_r.op == OP_ANDL) || (s_r.op == OP_RETLIT)) begin  // Literal operand
          s_nxt.operand = s_r.instr[7:0];
        end else if (s_r.addr == PORT_ADDR) begin
          s_nxt.operand = s_r.pinSync;
        end else begin
          s_nxt.operand = fileData;
        end
      end
      PH_Q3: begin
        s_nxt.phase = PH_Q4;
        s_nxt.fetch = 1'b1;
        s_nxt.result = aluBus.result;
        s_nxt.newFlags[FLAG_C] = aluBus.cout;
        s_nxt.newFlags[FLAG_DIG] = aluBus.digOut;
        s_nxt.newFlags[FLAG_Z] = aluBus.zOut;
        s_nxt.newFlags[FLAG_OVF] = aluBus.ovfOut;
        s_nxt.newFlags[FLAG_N] = aluBus.nOut;
        case (s_r.op)
          OP_CPEQ:   s_nxt.skip = (s_r.operand == s_r.acc);
          OP_CPGT:   s_nxt.skip = (s_r.operand > s_r.acc);
          OP_CPLT:   s_nxt.skip = (s_r.operand < s_r.acc);
          OP_DECSNZ: s_nxt.skip = (aluBus.result != 8'h00);
          OP_BTSC:   s_nxt.skip = !s_r.operand[s_r.instr[11:9]];
          OP_BTSS:   s_nxt.skip = s_r.operand[s_r.instr[11:9]];
          OP_BRANCH: s_nxt.skip = branchTrue(s_r.instr[10:8], s_r.flags);
          OP_SECOND: begin  // Jump lands with this fetch, so no flush is needed
            s_nxt.jump = 1'b1;
            s_nxt.jumpRel = 1'b0;
            s_nxt.jumpTgt = {s_r.instr[11:0], s_r.pendLow};
            s_nxt.push = s_r.pendCall;
          end
          default:   s_nxt.skip = 1'b0;
        endcase
      end
      default: begin
        s_nxt.phase = PH_Q1;
        if (byteOp(s_r.op)) begin
          if (s_r.instr[BIT_DEST]) begin
            s_nxt.fileWe = 1'b1;
            s_nxt.fileWd = s_r.result;
            s_nxt.prescClr = (s_r.addr == TIMER0_ADDR) && prescalerAssigned;
          end else begin
            s_nxt.acc = s_r.result;
          end
        end
        case (s_r.op)
          OP_ADDC, OP_SUB_AF, OP_SUB_FA: begin
            s_nxt.flags = s_r.newFlags;
          end
          OP_RLC: begin
            s_nxt.flags[FLAG_C] = s_r.newFlags[FLAG_C];
            s_nxt.flags[FLAG_Z] = s_r.newFlags[FLAG_Z];
            s_nxt.flags[FLAG_N] = s_r.newFlags[FLAG_N];
          end
          OP_ANDL: begin
            s_nxt.acc = s_r.result;
            s_nxt.flags[FLAG_Z] = s_r.newFlags[FLAG_Z];
            s_nxt.flags[FLAG_N] = s_r.newFlags[FLAG_N];
          end
          OP_RETLIT: begin
            s_nxt.acc = s_r.operand;
            s_nxt.pop = 1'b1;
          end
          OP_RETIRQ: begin
            s_nxt.pop = 1'b1;
            s_nxt.gieH = 1'b1;
            s_nxt.gieL = 1'b1;
          end
          OP_PUSH:  s_nxt.push = 1'b1;
          OP_SLEEP: begin
            s_nxt.sleep = 1'b1;
            s_nxt.wdtExp = 1'b0;
            s_nxt.pwrDown = 1'b1;
          end
          OP_CALL, OP_GOTO: begin
            s_nxt.pend = 1'b1;
            s_nxt.pendCall = (s_r.op == OP_CALL);
            s_nxt.pendLow = s_r.instr[7:0];
          end
          OP_BRANCH: begin
            s_nxt.jump = s_r.skip;
            s_nxt.jumpRel = 1'b1;
            s_nxt.jumpTgt = {{12{s_r.instr[7]}}, s_r.instr[7:0]};
          end
          default: ;
        endcase
        // The word fetched behind a taken skip, branch or return is dropped
        s_nxt.flush = s_r.skip || (s_r.op == OP_RETLIT) || (s_r.op == OP_RETIRQ);
      end
    endcase
  end

  // State register; the enable freezes everything, synchroniser included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.acc <= ACC_RST;
      s_r.flags <= FLAGS_RST;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign quarterPhase = s_r.phase;
  assign fetchStrobe = s_r.fetch;
  assign nopCycle = s_r.nop;
  assign dataAddr = s_r.addr;
  assign fileWriteEn = s_r.fileWe;
  assign fileWriteData = s_r.fileWd;
  assign accumulator = s_r.acc;
  assign statusFlags = s_r.flags;
  assign watchdogExpired = s_r.wdtExp;
  assign powerDown = s_r.pwrDown;
  assign gieHigh = s_r.gieH;
  assign gieLow = s_r.gieL;
  assign jumpEn = s_r.jump;
  assign jumpRelative = s_r.jumpRel;
  assign jumpTarget = s_r.jumpTgt;
  assign stackPush = s_r.push;
  assign stackPop = s_r.pop;
  assign sleepReq = s_r.sleep;
  assign prescalerClear = s_r.prescClr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  phase_decode_a: assert property ((clkEn && s_r.phase == PH_Q1) |=>
    (s_r.phase == PH_Q2) && (s_r.instr == $past(instrWord)))
    else $error("Q1 did not latch the word");
  addc_sum_a: assert property ((clkEn && s_r.phase == PH_Q3 && s_r.op == OP_ADDC) |=>
    s_r.result == 8'($past(s_r.acc) + $past(s_r.operand) + {7'h00, $past(s_r.flags[FLAG_C])}))
    else $error("Add with carry sum wrong");
  dest_file_a: assert property ((clkEn && s_r.phase == PH_Q4 && byteOp(s_r.op) &&
    s_r.instr[BIT_DEST]) |=> s_r.fileWe && (s_r.fileWd == $past(s_r.result)))
    else $error("File destination not written");
  dest_acc_a: assert property ((clkEn && s_r.phase == PH_Q4 && byteOp(s_r.op) &&
    !s_r.instr[BIT_DEST]) |=> !s_r.fileWe && (s_r.acc == $past(s_r.result)))
    else $error("Accumulator destination not written");
  skip_flush_a: assert property ((clkEn && s_r.phase == PH_Q4 && s_r.skip) |=>
    s_r.flush) else $error("Skip did not flush next word");
  flush_nop_a: assert property ((clkEn && s_r.phase == PH_Q1 && s_r.flush) |=>
    (s_r.op == OP_NOP) && s_r.nop) else $error("Flushed word executed");
  lone_second_a: assert property ((clkEn && s_r.phase == PH_Q1 && !s_r.pend &&
    (instrWord[15:12] == HI4_SECOND)) |=> s_r.op == OP_NOP)
    else $error("Lone second word not a no-op");
  call_pair_a: assert property ((clkEn && s_r.phase == PH_Q1 && s_r.pend && s_r.pendCall &&
    !s_r.flush && (instrWord[15:12] == HI4_SECOND)) ##1 clkEn [*2] |=> s_r.jump && s_r.push)
    else $error("Call did not jump and push");
  dec_flags_a: assert property ((clkEn && s_r.phase == PH_Q4 && s_r.op == OP_DECSNZ) |=>
    $stable(s_r.flags)) else $error("Decrement skip changed flags");
  and_flags_a: assert property ((clkEn && s_r.phase == PH_Q4 && s_r.op == OP_ANDL) |=>
    (s_r.flags[FLAG_C] == $past(s_r.flags[FLAG_C])) && (s_r.acc == $past(s_r.result)))
    else $error("AND literal result or carry wrong");
  sleep_flags_a: assert property (s_r.sleep |-> s_r.pwrDown && !s_r.wdtExp)
    else $error("Sleep flags not updated");
  port_src_a: assert property ((clkEn && s_r.phase == PH_Q2 && s_r.addr == PORT_ADDR &&
    s_r.op != OP_ANDL && s_r.op != OP_RETLIT) |=> s_r.operand == $past(s_r.pinSync))
    else $error("Port operand not from pins");
  presc_clear_a: assert property (s_r.prescClr |->
    s_r.fileWe && (s_r.addr == TIMER0_ADDR))
    else $error("Prescaler clear without timer write");

  call_seen_c: cover property (s_r.jump && s_r.push);
  skip_taken_c: cover property (s_r.phase == PH_Q4 && s_r.skip && s_r.op != OP_BRANCH);
  branch_taken_c: cover property (s_r.jump && s_r.jumpRel);
  sleep_seen_c: cover property (s_r.sleep);
endmodule
`default_nettype wire

// >>> sim/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory: word at pc, steps or loads an absolute jump target on each fetch strobe
module prog_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        fetchStrobe,
  input  wire logic        jumpEn,
  input  wire logic        jumpRelative,
  input  wire logic [19:0] jumpTarget,
  output logic [15:0]      instrWord
);
  logic [15:0] rom [0:15];  // Filled by the bench
  logic [3:0]  pc;          // Word address
  assign instrWord = rom[pc];
  // Relative loads are not followed: programs hold no-ops past them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc <= 4'h0;
    end else if (clkEn && fetchStrobe) begin
      pc <= (jumpEn && !jumpRelative) ? jumpTarget[3:0] : pc + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/cpu8_instruction_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module cpu8_instruction_decode_bench;
  import cpu8_decode_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [7:0]  fd, pin, acc;
    logic [4:0]  fl;
    logic [7:0]  wd;
  } row_s;
  logic        clock = 1'b0, rst_n = 1'b0, extendedEn = 1'b0, prescalerAssigned = 1'b0;
  logic        clkEn = 1'b1, rel;  // Enable is driven so a freeze can be tried
  logic [7:0]  fileData = 8'h00, portPins = 8'h00;
  logic [3:0]  bankSelect = 4'h0;
  logic [11:0] indexBase = 12'h000, addr;
  logic [1:0]  qp, quarterPhase;
  logic [15:0] instrWord;
  logic        fetchStrobe, nopCycle, fileWriteEn, watchdogExpired, powerDown, gieHigh, gieLow;
  logic        jumpEn, jumpRelative, stackPush, stackPop, sleepReq, prescalerClear;
  logic [11:0] dataAddr;
  logic [7:0]  fileWriteData, accumulator;
  logic [4:0]  statusFlags;
  logic [19:0] jumpTarget, tgt;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  int nJump, nPush, nPop, nSleep, nPre, nNop, nFetch, nWe;
  // Accumulator and flags start at zero after each reset
  row_s rows [10] = '{
    '{16'h2012, 8'h05, 8'h00, 8'h05, 5'h00, 8'h00}, '{16'h2212, 8'h05, 8'h00, 8'h00, 5'h00, 8'h05},
    '{16'h2012, 8'h00, 8'h00, 8'h00, 5'h04, 8'h00}, '{16'h2080, 8'h00, 8'h33, 8'h33, 5'h00, 8'h00},
    '{16'h5412, 8'h01, 8'h00, 8'hfe, 5'h10, 8'h00}, '{16'h5812, 8'h05, 8'h00, 8'h04, 5'h03, 8'h00},
    '{16'h3412, 8'h81, 8'h00, 8'h02, 5'h01, 8'h00}, '{16'h4e12, 8'h03, 8'h00, 8'h00, 5'h00, 8'h02},
    '{16'h0c5a, 8'h00, 8'h00, 8'h5a, 5'h00, 8'h00}, '{16'h0bff, 8'h00, 8'h00, 8'h00, 5'h04, 8'h00}};
  always #10 clock = ~clock;
  cpu8_instruction_decode cpu8_instruction_decode_inst (.clock(clock), .rst_n(rst_n),
    .clkEn(clkEn), .instrWord(instrWord), .fileData(fileData), .portPins(portPins),
    .bankSelect(bankSelect), .indexBase(indexBase), .extendedEn(extendedEn),
    .prescalerAssigned(prescalerAssigned), .quarterPhase(quarterPhase),
    .fetchStrobe(fetchStrobe), .nopCycle(nopCycle), .dataAddr(dataAddr),
    .fileWriteEn(fileWriteEn), .fileWriteData(fileWriteData), .accumulator(accumulator),
    .statusFlags(statusFlags), .watchdogExpired(watchdogExpired), .powerDown(powerDown),
    .gieHigh(gieHigh), .gieLow(gieLow), .jumpEn(jumpEn), .jumpRelative(jumpRelative),
    .jumpTarget(jumpTarget), .stackPush(stackPush), .stackPop(stackPop),
    .sleepReq(sleepReq), .prescalerClear(prescalerClear));
  prog_mem_model prog_mem_model_inst (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .fetchStrobe(fetchStrobe), .jumpEn(jumpEn), .jumpRelative(jumpRelative),
    .jumpTarget(jumpTarget), .instrWord(instrWord));
  // Pulse counters sampled mid-cycle, away from the launching edge
  always @(negedge clock) begin
    cycles++;
    nJump += int'(jumpEn); nPush += int'(stackPush); nPop += int'(stackPop);
    nSleep += int'(sleepReq); nPre += int'(prescalerClear); nNop += int'(nopCycle);
    nFetch += int'(fetchStrobe); nWe += int'(fileWriteEn);
    if (jumpEn) begin
      tgt = jumpTarget;
      rel = jumpRelative;
    end
    if (cycles > 3000) begin
      n_mismatch++;  // Hang guard
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Load a short program, reset, then run 2 + n cycles
  task automatic run(input logic [15:0] w0, w1, w2, input int n);
    for (int i = 0; i < 16; i++) prog_mem_model_inst.rom[i] = 16'h0000;
    prog_mem_model_inst.rom[0] = w0; prog_mem_model_inst.rom[1] = w1;
    prog_mem_model_inst.rom[2] = w2;
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    {nJump, nPush, nPop, nSleep, nPre, nNop, nFetch, nWe} = '0;
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    addr = dataAddr; qp = quarterPhase;  // Operand address stands from Q2
    repeat (n) @(negedge clock);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    `CHK("reset", 15'h0, {quarterPhase, accumulator, statusFlags})
    foreach (rows[i]) begin
      fileData = rows[i].fd; portPins = rows[i].pin;
      // Second slot: the pin synchroniser needs two edges after reset to fill
      run(16'h0, rows[i].w, 16'h0, 10);
      `CHK("row", {rows[i].acc, rows[i].fl, rows[i].wd}, {accumulator, statusFlags, fileWriteData})
      `CHK("fetches", 3, nFetch)
      $display("row %0d done", i);
    end
    fileData = 8'h00;
    // Equal skips the two-word jump; greater and less do not skip
    for (int i = 0; i < 3; i++) begin
      run({12'h620, 4'h2} - {12'h0, 4'h2 * i[3:0]} + 16'h0200 * (i == 1), 16'hef05, 16'hf000, 20);
      `CHK("cmp jumps", (i == 0) ? 0 : 1, nJump)
      if (i == 0) `CHK("cmp flush", 1'b1, nNop != 0)
    end
    for (int i = 0; i < 2; i++) begin
      run(i ? 16'hec05 : 16'hef05, 16'hf000, 16'h0, 12);
      `CHK("far jump", {1'b0, 20'h00005, 8'h1, 8'(i)}, {rel, tgt, 8'(nJump), 8'(nPush)})
    end
    for (int i = 0; i < 2; i++) begin
      run(i ? 16'he102 : 16'he002, 16'h0, 16'h0, 12);
      `CHK("branch", {8'(i), 1'(i)}, {8'(nJump), nNop != 0})
      if (i == 1) `CHK("branch target", 21'h100002, {rel, tgt})
    end
    $display("control flow done");
    run(16'hf123, 16'h0, 16'h0, 8);
    `CHK("lone second word", 16'h0, {8'(nJump), accumulator})
    run(16'h0003, 16'h0, 16'h0, 8);
    `CHK("sleep", 3'b110, {nSleep == 1, powerDown, watchdogExpired})
    run(16'h0010, 16'h0, 16'h0, 8);
    `CHK("irq return", 3'b111, {gieHigh, gieLow, nPop == 1})
    run(16'h0005, 16'h0, 16'h0, 8);
    `CHK("push", 6'h20, {nPush == 1, statusFlags})
    prescalerAssigned = 1'b1; fileData = 8'h01;
    run(16'h22d0, 16'h0, 16'h0, 8);
    `CHK("prescaler", 4'b1110, {nPre == 1, nWe == 1, qp})
    bankSelect = 4'h3;
    run(16'h2112, 16'h0, 16'h0, 4);
    `CHK("banked addr", 12'h312, addr)
    extendedEn = 1'b1; indexBase = 12'h100;
    run(16'h2012, 16'h0, 16'h0, 4);
    `CHK("indexed addr", 12'h112, addr)
    // Six enabled edges after release leave Q3; a low enable must hold it
    clkEn = 1'b0;
    repeat (5) @(negedge clock);
    `CHK("freeze", 2'h2, quarterPhase)
    clkEn = 1'b1;
    $display("special cases done");
    complete_run();
  end
endmodule
`default_nettype wire
